// ==== rtl/fpcg_pkg.sv ====
// constants, register map and command codes for the flash command gate host
package fpcg_pkg;

    // timing
    localparam int CLK_NS   = 25;
    localparam int T_WP_NS  = 35;     // write enable low width
    localparam int T_WPH_NS = 20;     // data hold after write enable rise
    localparam int T_ACC_NS = 100;    // read access
    localparam int T_RP_NS  = 500;    // hardware reset pulse
    localparam int T_VID_NS = 4000;   // high voltage settle
    localparam int SYNC_CYC = 2;
    localparam logic [7:0] WP_CYC  = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] WPH_CYC = 8'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
    localparam logic [7:0] RP_CYC  = 8'((T_RP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] VID_CYC = 8'((T_VID_NS + CLK_NS - 1) / CLK_NS);

    // widths and pin fields
    localparam int ADDR_W          = 24;
    localparam int DQ_W            = 16;
    localparam int BIT_ID_HV       = 10;
    localparam int BIT_PROTECT_SEL = 7;
    localparam int BIT_VERIFY_SEL  = 2;
    localparam int BIT_CODE_SEL    = 1;
    localparam int SECT_LSB        = 16;

    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_RDATA  = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_MODE   = 8'h14;

    // register fields
    localparam int CTRL_GO_BIT    = 0;
    localparam int CTRL_OP_LSB    = 4;
    localparam int MODE_UNPROT    = 0;
    localparam int MODE_ERASE_CLR = 1;
    localparam int ST_BUSY        = 0;
    localparam int ST_DONE        = 1;
    localparam int ST_REFUSED     = 2;
    localparam int ST_SECURED     = 3;
    localparam int ST_ERASE       = 4;

    // operation codes
    localparam logic [3:0] OP_READ    = 4'h0;
    localparam logic [3:0] OP_WRITE   = 4'h1;
    localparam logic [3:0] OP_RESET   = 4'h2;
    localparam logic [3:0] OP_ENTER   = 4'h3;
    localparam logic [3:0] OP_EXIT    = 4'h4;
    localparam logic [3:0] OP_PROGRAM = 4'h5;
    localparam logic [3:0] OP_ID      = 4'h6;
    localparam logic [3:0] OP_VERIFY  = 4'h7;
    localparam logic [3:0] OP_HWRESET = 4'h8;
    localparam logic [3:0] OP_ERASE   = 4'h9;
    localparam logic [3:0] OP_SUSPEND = 4'ha;
    localparam logic [3:0] OP_RESUME  = 4'hb;

    // command addresses and data
    localparam logic [23:0] UNLOCK1_ADDR = 24'h000555;
    localparam logic [23:0] UNLOCK2_ADDR = 24'h0002aa;
    localparam logic [15:0] CMD_AA       = 16'h00aa;
    localparam logic [15:0] CMD_55       = 16'h0055;
    localparam logic [15:0] CMD_ENTER    = 16'h0088;
    localparam logic [15:0] CMD_AUTOSEL  = 16'h0090;
    localparam logic [15:0] CMD_EXIT     = 16'h0000;
    localparam logic [15:0] CMD_PROGRAM  = 16'h00a0;
    localparam logic [15:0] CMD_ERASE    = 16'h0080;
    localparam logic [15:0] CMD_SECT_ER  = 16'h0030;
    localparam logic [15:0] CMD_RESET    = 16'h00f0;
    localparam logic [15:0] CMD_SUSPEND  = 16'h00b0;
    localparam logic [15:0] CMD_RESUME   = 16'h0030;

endpackage

// ==== rtl/fpcg_cycle.sv ====
// one asynchronous flash bus cycle, write or read, with pin timing
`timescale 1ns/1ps
`default_nettype none
module fpcg_cycle (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // request
    input  wire logic        start,
    input  wire logic        is_write,
    input  wire logic [23:0] addr,
    input  wire logic [15:0] wdata,
    output logic             done,
    output logic [15:0]      rdata,
    // flash pins
    output logic [23:0]      flash_addr,
    output logic [15:0]      dq_o,
    output logic             dq_oe,
    input  wire logic [15:0] dq_i,
    output logic             chip_select_n,
    output logic             we_n,
    output logic             oe_n
);

    typedef enum logic [2:0] {C_IDLE, C_SETUP, C_PULSE, C_HOLD, C_READ} fpcg_cyc_e;

    fpcg_cyc_e   st_q;
    logic [7:0]  cnt_q;
    logic [15:0] dq_s1_q;
    logic [15:0] dq_s2_q;

    // two-stage synchroniser on the data bus
    always_ff @(posedge clock) begin
        dq_s1_q <= dq_i;
        dq_s2_q <= dq_s1_q;
    end

    // cycle sequencer; strobes idle high from reset so no stray command edge
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q          <= C_IDLE;
            cnt_q         <= 8'h00;
            done          <= 1'b0;
            rdata         <= 16'h0000;
            flash_addr    <= 24'h000000;
            dq_o          <= 16'h0000;
            dq_oe         <= 1'b0;
            chip_select_n <= 1'b1;
            we_n          <= 1'b1;
            oe_n          <= 1'b1;
        end else begin
            done <= 1'b0;
            case (st_q)
                C_IDLE: begin
                    if (start) begin
                        flash_addr    <= addr;          // set with chip select, before write enable falls
                        chip_select_n <= 1'b0;
                        if (is_write) begin
                            dq_o  <= wdata;
                            dq_oe <= 1'b1;
                            oe_n  <= 1'b1;              // output enable high for write
                            st_q  <= C_SETUP;
                        end else begin
                            oe_n  <= 1'b0;
                            cnt_q <= fpcg_pkg::ACC_CYC;
                            st_q  <= C_READ;
                        end
                    end
                end
                C_SETUP: begin
                    we_n  <= 1'b0;                      // later falling edge is write enable
                    cnt_q <= fpcg_pkg::WP_CYC;          // pulse well above glitch width
                    st_q  <= C_PULSE;
                end
                C_PULSE: begin
                    if (cnt_q <= 8'h01) begin
                        we_n  <= 1'b1;                  // earliest rise latches data
                        cnt_q <= fpcg_pkg::WPH_CYC;
                        st_q  <= C_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                C_HOLD: begin
                    if (cnt_q <= 8'h01) begin
                        chip_select_n <= 1'b1;
                        dq_oe         <= 1'b0;
                        done          <= 1'b1;
                        st_q          <= C_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                C_READ: begin
                    if (cnt_q <= 8'h01) begin
                        rdata         <= dq_s2_q;
                        chip_select_n <= 1'b1;
                        oe_n          <= 1'b1;
                        done          <= 1'b1;
                        st_q          <= C_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: st_q <= C_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

// ==== rtl/fpcg_host.sv ====
// apb-controlled host that drives flash protect, id and secured-region sequences
`timescale 1ns/1ps
`default_nettype none
module fpcg_host (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // flash bus
    output logic [23:0]      flash_addr,
    output logic [15:0]      dq_o,
    output logic             dq_oe,
    input  wire logic [15:0] dq_i,
    output logic             chip_select_n,
    output logic             we_n,
    output logic             oe_n,
    // flash reset and high-voltage controls
    output logic             reset_out_n,
    output logic             reset_vid_en,
    output logic             id_vid_en
);

    typedef enum logic [2:0] {S_IDLE, S_SETTLE, S_ISSUE, S_WAIT, S_RSTPULSE} fpcg_state_e;

    fpcg_state_e st_q;
    logic [3:0]  op_q;
    logic [2:0]  step_q;
    logic [7:0]  cnt_q;
    logic [23:0] addr_q;
    logic [15:0] wdata_q;
    logic [15:0] rdata_q;
    logic        done_q;
    logic        refused_q;
    logic        secured_q;
    logic        erase_q;
    logic        unprot_q;
    logic        cyc_done;
    logic [15:0] cyc_rdata;
    logic        cyc_write;
    logic [23:0] cyc_addr;
    logic [15:0] cyc_data;
    logic        wr_en;
    logic        go;
    logic [3:0]  go_op;
    logic        busy;
    logic        addr_ok;

    // number of bus cycles in each operation except the hardware reset, which issues none
    function automatic logic [2:0] seq_len(input logic [3:0] op);
        case (op)
            fpcg_pkg::OP_ENTER:   seq_len = 3'd3;
            fpcg_pkg::OP_EXIT,
            fpcg_pkg::OP_PROGRAM: seq_len = 3'd4;
            fpcg_pkg::OP_ERASE:   seq_len = 3'd6;
            default:              seq_len = 3'd1;
        endcase
    endfunction

    // operations that are reads rather than command writes
    function automatic logic is_read_op(input logic [3:0] op);
        is_read_op = (op == fpcg_pkg::OP_READ) || (op == fpcg_pkg::OP_ID) || (op == fpcg_pkg::OP_VERIFY);
    endfunction

    assign busy    = (st_q != S_IDLE);
    assign wr_en   = psel && penable && pwrite;
    assign go      = wr_en && (paddr == fpcg_pkg::REG_CTRL) && pwdata[fpcg_pkg::CTRL_GO_BIT];
    assign go_op   = pwdata[fpcg_pkg::CTRL_OP_LSB +: 4];
    assign addr_ok = (paddr == fpcg_pkg::REG_CTRL) || (paddr == fpcg_pkg::REG_ADDR)
                  || (paddr == fpcg_pkg::REG_WDATA) || (paddr == fpcg_pkg::REG_RDATA)
                  || (paddr == fpcg_pkg::REG_STATUS) || (paddr == fpcg_pkg::REG_MODE);
    assign pready  = psel && penable;
    assign pslverr = psel && penable && !addr_ok;

    // address and data of the current bus cycle
    always_comb begin
        cyc_write = !is_read_op(op_q);
        cyc_addr  = addr_q;
        cyc_data  = wdata_q;
        if (step_q == 3'd0 && seq_len(op_q) > 3'd1) begin
            cyc_addr = fpcg_pkg::UNLOCK1_ADDR;
            cyc_data = fpcg_pkg::CMD_AA;
        end else if (step_q == 3'd1 || step_q == 3'd4) begin
            cyc_addr = fpcg_pkg::UNLOCK2_ADDR;
            cyc_data = fpcg_pkg::CMD_55;
        end else if (step_q == 3'd3 && op_q == fpcg_pkg::OP_ERASE) begin
            cyc_addr = fpcg_pkg::UNLOCK1_ADDR;
            cyc_data = fpcg_pkg::CMD_AA;
        end
        case (op_q)
            fpcg_pkg::OP_ENTER: begin
                if (step_q == 3'd2) begin
                    cyc_addr = fpcg_pkg::UNLOCK1_ADDR;
                    cyc_data = fpcg_pkg::CMD_ENTER;
                end
            end
            fpcg_pkg::OP_EXIT: begin
                if (step_q == 3'd2) begin
                    cyc_addr = fpcg_pkg::UNLOCK1_ADDR;
                    cyc_data = fpcg_pkg::CMD_AUTOSEL;
                end else if (step_q == 3'd3) begin
                    cyc_data = fpcg_pkg::CMD_EXIT;        // any address
                end
            end
            fpcg_pkg::OP_PROGRAM: begin
                if (step_q == 3'd2) begin
                    cyc_addr = fpcg_pkg::UNLOCK1_ADDR;
                    cyc_data = fpcg_pkg::CMD_PROGRAM;
                end
            end
            fpcg_pkg::OP_ERASE: begin
                if (step_q == 3'd2) begin
                    cyc_addr = fpcg_pkg::UNLOCK1_ADDR;
                    cyc_data = fpcg_pkg::CMD_ERASE;
                end else if (step_q == 3'd5) begin
                    cyc_data = fpcg_pkg::CMD_SECT_ER;     // sector on upper bits
                end
            end
            fpcg_pkg::OP_RESET:   cyc_data = fpcg_pkg::CMD_RESET;
            fpcg_pkg::OP_SUSPEND: cyc_data = fpcg_pkg::CMD_SUSPEND;
            fpcg_pkg::OP_RESUME:  cyc_data = fpcg_pkg::CMD_RESUME;
            fpcg_pkg::OP_ID: begin
                cyc_addr[fpcg_pkg::BIT_ID_HV]       = 1'b1;
                cyc_addr[fpcg_pkg::BIT_PROTECT_SEL] = 1'b0;
                cyc_addr[fpcg_pkg::BIT_VERIFY_SEL]  = 1'b0;         // bit 1 from software
            end
            fpcg_pkg::OP_VERIFY: begin
                cyc_addr[fpcg_pkg::BIT_ID_HV]       = 1'b1;
                cyc_addr[fpcg_pkg::BIT_PROTECT_SEL] = 1'b0;
                cyc_addr[fpcg_pkg::BIT_CODE_SEL]    = 1'b0;
                cyc_addr[fpcg_pkg::BIT_VERIFY_SEL]  = 1'b1;         // read keeps we high
            end
            default: ;
        endcase
    end

    // operation sequencer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_q        <= S_IDLE;
            op_q        <= fpcg_pkg::OP_READ;
            step_q      <= 3'd0;
            cnt_q       <= 8'h00;
            id_vid_en   <= 1'b0;
            reset_out_n <= 1'b1;
        end else begin
            case (st_q)
                S_IDLE: begin
                    step_q <= 3'd0;
                    if (go && !((go_op == fpcg_pkg::OP_SUSPEND || go_op == fpcg_pkg::OP_RESUME) && !erase_q)
                        && go_op <= fpcg_pkg::OP_RESUME) begin
                        op_q <= go_op;
                        if (go_op == fpcg_pkg::OP_ID || go_op == fpcg_pkg::OP_VERIFY) begin
                            id_vid_en <= 1'b1;
                            cnt_q     <= fpcg_pkg::VID_CYC;
                            st_q      <= S_SETTLE;
                        end else if (go_op == fpcg_pkg::OP_HWRESET) begin
                            reset_out_n <= 1'b0;
                            cnt_q       <= fpcg_pkg::RP_CYC;
                            st_q        <= S_RSTPULSE;
                        end else begin
                            st_q <= S_ISSUE;
                        end
                    end
                end
                S_SETTLE: begin
                    if (cnt_q <= 8'h01) begin
                        st_q <= S_ISSUE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                S_ISSUE: st_q <= S_WAIT;
                S_WAIT: begin
                    if (cyc_done) begin
                        if (step_q == seq_len(op_q) - 3'd1) begin
                            id_vid_en <= 1'b0;
                            st_q      <= S_IDLE;
                        end else begin
                            step_q <= step_q + 3'd1;                  // whole sequence back to back
                            st_q   <= S_ISSUE;
                        end
                    end
                end
                S_RSTPULSE: begin
                    if (cnt_q <= 8'h01) begin
                        reset_out_n <= 1'b1;
                        st_q        <= S_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    // status flags; a set from the sequencer wins over software clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            done_q    <= 1'b0;
            refused_q <= 1'b0;
            secured_q <= 1'b0;
            erase_q   <= 1'b0;
            rdata_q   <= 16'h0000;
        end else begin
            if (go) begin
                done_q    <= 1'b0;
                refused_q <= busy || go_op > fpcg_pkg::OP_RESUME
                          || ((go_op == fpcg_pkg::OP_SUSPEND || go_op == fpcg_pkg::OP_RESUME) && !erase_q);
            end
            if (wr_en && paddr == fpcg_pkg::REG_MODE && pwdata[fpcg_pkg::MODE_ERASE_CLR]) begin
                erase_q <= 1'b0;
            end
            if (st_q == S_WAIT && cyc_done && step_q == seq_len(op_q) - 3'd1) begin
                done_q <= 1'b1;
                if (!cyc_write) begin
                    rdata_q <= cyc_rdata;
                end
                if (op_q == fpcg_pkg::OP_ENTER) secured_q <= 1'b1;
                if (op_q == fpcg_pkg::OP_EXIT) secured_q <= 1'b0;
                if (op_q == fpcg_pkg::OP_ERASE) erase_q <= 1'b1;
                if (op_q == fpcg_pkg::OP_RESET) erase_q <= 1'b0;
            end
            if (st_q == S_RSTPULSE && cnt_q <= 8'h01) begin
                done_q    <= 1'b1;
                secured_q <= 1'b0;
                erase_q   <= 1'b0;
            end
        end
    end

    // software registers and reset high-voltage level
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            addr_q   <= 24'h000000;
            wdata_q  <= 16'h0000;
            unprot_q <= 1'b0;
        end else if (wr_en && !busy) begin
            if (paddr == fpcg_pkg::REG_ADDR) addr_q <= pwdata[23:0];
            if (paddr == fpcg_pkg::REG_WDATA) wdata_q <= pwdata[15:0];
            if (paddr == fpcg_pkg::REG_MODE) unprot_q <= pwdata[fpcg_pkg::MODE_UNPROT];
        end
    end

    assign reset_vid_en = unprot_q;    // held high: temporary unprotect

    // read data registered in the setup phase
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            case (paddr)
                fpcg_pkg::REG_CTRL:   prdata <= {24'h000000, op_q, 4'h0};
                fpcg_pkg::REG_ADDR:   prdata <= {8'h00, addr_q};
                fpcg_pkg::REG_WDATA:  prdata <= {16'h0000, wdata_q};
                fpcg_pkg::REG_RDATA:  prdata <= {16'h0000, rdata_q};
                fpcg_pkg::REG_STATUS: prdata <= {27'h0000000, erase_q, secured_q, refused_q, done_q, busy};
                fpcg_pkg::REG_MODE:   prdata <= {31'h00000000, unprot_q};
                default:              prdata <= 32'h00000000;
            endcase
        end
    end

    // bus cycle engine
    fpcg_cycle u_cycle (
        .clock         (clock),
        .rst_n         (rst_n),
        .start         (st_q == S_ISSUE),
        .is_write      (cyc_write),
        .addr          (cyc_addr),
        .wdata         (cyc_data),
        .done          (cyc_done),
        .rdata         (cyc_rdata),
        .flash_addr    (flash_addr),
        .dq_o          (dq_o),
        .dq_oe         (dq_oe),
        .dq_i          (dq_i),
        .chip_select_n (chip_select_n),
        .we_n          (we_n),
        .oe_n          (oe_n)
    );

endmodule
`default_nettype wire

// ==== dv/fpcg_chk.sv ====
// assertions on the host's flash pins
`timescale 1ns/1ps
`default_nettype none
module fpcg_chk (
    // watched ports
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [23:0] flash_addr,
    input wire logic        dq_oe,
    input wire logic        chip_select_n,
    input wire logic        we_n,
    input wire logic        oe_n,
    input wire logic        reset_out_n,
    input wire logic        id_vid_en
);
    // single clock domain
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // strobe, data and high-voltage relations
    AST_WE_GATE: assert property (!we_n |-> !chip_select_n && oe_n) else $error("we gate");
    AST_OE_FREE: assert property (!oe_n |-> !dq_oe && we_n) else $error("read clash");
    AST_WE_WIDTH: assert property ($fell(we_n) |=> !we_n ##1 we_n) else $error("we width");
    AST_DATA_HOLD: assert property ($rose(we_n) |-> dq_oe && !chip_select_n) else $error("hold");
    AST_ADDR_HOLD: assert property (!we_n |-> $stable(flash_addr)) else $error("addr");
    AST_ID_PINS: assert property (id_vid_en && !oe_n |-> flash_addr[10] && !flash_addr[7])
        else $error("id pins");
    AST_VFY_PINS: assert property (id_vid_en && !oe_n && flash_addr[2] |-> we_n && !flash_addr[1])
        else $error("verify pins");
    AST_RST_PULSE: assert property ($fell(reset_out_n) |=> !reset_out_n [*8]) else $error("pulse");
    // scenarios reached
    cover property ($fell(we_n));
    cover property ($rose(id_vid_en));
    cover property ($fell(reset_out_n));
endmodule
bind fpcg_host fpcg_chk u_chk (.clock(clock), .rst_n(rst_n), .flash_addr(flash_addr), .dq_oe(dq_oe),
    .chip_select_n(chip_select_n), .we_n(we_n), .oe_n(oe_n), .reset_out_n(reset_out_n), .id_vid_en(id_vid_en));
`default_nettype wire

// ==== dv/fpcg_flash.sv ====
// flash part model driven by the host
`timescale 1ns/1ps
`default_nettype none
module fpcg_flash #(parameter logic [15:0] MFR = 16'h005a, DEV = 16'h0a5c, parameter logic IND = 1'b0) ( // arbitrary codes
    // flash pins
    input  wire logic [23:0] flash_addr,
    input  wire logic [15:0] dq_o,
    input  wire logic        chip_select_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic        reset_out_n,
    input  wire logic        reset_vid_en,
    input  wire logic        id_vid_en,
    output logic      [15:0] dq_i
);
    logic [15:0] mem [512];
    logic [15:0] v;
    logic [23:0] a;
    logic [2:0]  st = 3'h0; // read mode at power-up
    logic        sec = 1'b0;
    // erased array
    initial foreach (mem[i]) mem[i] = 16'hffff;
    // address on the falling strobe
    always @(negedge we_n) a = flash_addr;
    // hardware reset leaves secured mode
    always @(negedge reset_out_n) {st, sec} = 4'h0;
    // decoder on the rising strobe, bad step back to read
    always @(posedge we_n) if (!chip_select_n && oe_n) begin
        // whole sequence only, locked group unless high voltage
        // a factory-locked secured region takes no change
        if (st == 3'h4 && (a[23:16] != 8'h01 || reset_vid_en) && !(IND && sec && a[23:7] == 17'h0))
            mem[{sec && a[23:7] == 17'h0, a[16], a[6:0]}] = dq_o;
        if (st == 3'h2 && dq_o == 16'h0088) sec = 1'b1;
        if (st == 3'h3 && dq_o == 16'h0000) sec = 1'b0;
        st = st == 3'h0 ? {2'h0, a[10:0] == 11'h555 && dq_o == 16'h00aa} // upper bits ignored
           : st == 3'h1 ? (a[10:0] == 11'h2aa && dq_o == 16'h0055 ? 3'h2 : 3'h0)
           : st == 3'h2 ? (dq_o == 16'h0090 ? 3'h3 : dq_o == 16'h00a0 ? 3'h4 : 3'h0) : 3'h0;
    end
    // id code, group status, secured word or array
    always_comb begin
        if (id_vid_en) v = flash_addr[2] ? {15'h0, flash_addr[23:16] == 8'h01} : flash_addr[1] ? DEV : MFR;
        else if (st == 3'h3 && flash_addr[7:0] == 8'h03) v = {8'h0, IND, 7'h0}; // indicator
        else v = mem[{sec && flash_addr[23:7] == 17'h0, flash_addr[16], flash_addr[6:0]}];
    end
    // released bus shows the inverse word
    assign dq_i = !chip_select_n && !oe_n ? v : ~v;
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
// self-checking bench for the flash command gate host
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [15:0] MFR = 16'h005a, DEV = 16'h0a5c; // arbitrary codes
    localparam logic        IND = 1'b0; // customer-lockable part
    logic        clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd, d;
    int          fails = 0, compares = 0, seed = 43;
    wire logic [31:0] prdata;
    wire logic [23:0] fa;
    wire logic [15:0] dqo, dqi;
    wire logic        pready, pslverr, cs_n, we_n, oe_n, ro_n, rv, iv;
    // 25 ns clock
    always #12.5 clock = ~clock;
    fpcg_host uut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr(fa), .dq_o(dqo),
        .dq_oe(), .dq_i(dqi), .chip_select_n(cs_n), .we_n(we_n), .oe_n(oe_n), .reset_out_n(ro_n),
        .reset_vid_en(rv), .id_vid_en(iv));
    fpcg_flash #(.MFR(MFR), .DEV(DEV), .IND(IND)) mdl (.flash_addr(fa), .dq_o(dqo), .chip_select_n(cs_n), .we_n(we_n),
        .oe_n(oe_n), .reset_out_n(ro_n), .reset_vid_en(rv), .id_vid_en(iv), .dq_i(dqi));
    // count a comparison, report a mismatch
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin fails++; $display("ERROR %s expected %h seen %h", n, e, g); end
    endtask
    // apb transfer held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata; err = pslverr; psel <= 1'b0; penable <= 1'b0;
    endtask
    // one host operation, bounded wait for done, then its read data
    task automatic op(input logic [3:0] o, input logic [23:0] a, input logic [15:0] wd);
        apb(1'b1, 8'h04, {8'h0, a}); apb(1'b1, 8'h08, {16'h0, wd}); apb(1'b1, 8'h00, {24'h0, o, 4'h1}); rd = 0;
        repeat (300) if (rd[1] !== 1'b1) apb(1'b0, 8'h10, 32'h0);
        if (rd[1] !== 1'b1) begin fails++; $display("ERROR done expected 1 seen %b", rd[1]); end
        apb(1'b0, 8'h0c, 32'h0);
    endtask
    // counts and verdict
    task automatic finish_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // watchdog far beyond the expected run
    initial begin #2000000; fails++; finish_test(); end
    // main sequence
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        apb(1'b0, 8'h18, 32'h0); chk("unmapped error", 1, err); $display("map test done");
        for (int i = 0; i < 3; i++) begin // random words in an open sector
            d = $random(seed);
            op(4'h5, {17'h0, 1'b1, d[21:16]}, d[15:0]);
            op(4'h0, {17'h0, 1'b1, d[21:16]}, 16'h0); chk("array word", {16'h0, d[15:0]}, rd);
        end
        for (int j = 0; j < 3; j++) begin // locked, temporarily open, locked again
            apb(1'b1, 8'h14, {31'h0, j == 1});
            op(4'h5, 24'h010040, 16'h1230 + 16'(j));
            op(4'h0, 24'h010040, 16'h0); chk("locked word", j ? 32'h1231 : 32'hffff, rd);
        end
        op(4'h6, 24'h0, 16'h0); chk("maker code", {16'h0, MFR}, rd);
        op(4'h6, 24'h2, 16'h0); chk("part code", {16'h0, DEV}, rd);
        op(4'h7, 24'h010000, 16'h0); chk("locked group", 1, rd[0]);
        op(4'h7, 24'h020000, 16'h0); chk("open group", 0, rd[0]);
        op(4'h3, 24'h0, 16'h0); apb(1'b0, 8'h10, 32'h0); chk("secured flag", 1, rd[3]);
        op(4'h5, 24'h000005, d[15:0]); op(4'h0, 24'h000005, 16'h0); chk("secured word", {16'h0, d[15:0]}, rd);
        op(4'h4, 24'h0, 16'h0); op(4'h0, 24'h000005, 16'h0); chk("first sector", 32'hffff, rd);
        op(4'h3, 24'h0, 16'h0); op(4'h8, 24'h0, 16'h0); op(4'h0, 24'h000005, 16'h0);
        chk("after pulse", 32'hffff, rd);
        op(4'h9, 24'h020000, 16'h0); op(4'ha, 24'h020000, 16'h0); apb(1'b0, 8'h10, 32'h0);
        chk("suspend taken", 32'h12, rd[4:0]);
        op(4'h1, 24'h000555, 16'h00aa); op(4'h1, 24'h0002aa, 16'h0055); op(4'h1, 24'h000555, 16'h0090);
        op(4'h0, 24'h000003, 16'h0); chk("indicator", IND, rd[7]);
        op(4'h2, 24'h0, 16'h0); apb(1'b0, 8'h10, 32'h0); chk("erase cleared", 0, rd[4]);
        op(4'h0, 24'h000003, 16'h0); chk("read mode", 32'hffff, rd);
        apb(1'b1, 8'h00, 32'h000000a1); apb(1'b0, 8'h10, 32'h0); chk("refused", 1, rd[2]);
        $display("flash tests done");
        finish_test();
    end
endmodule
`default_nettype wire
